// file: fp_fmt_pkg.sv
package fp_fmt_pkg;

    // Double precision layout
    localparam int DP_EXP_W      = 11;
    localparam int DP_MAN_W      = 52;
    localparam int DP_SIGN_POS   = 63;
    localparam int DP_EXP_LSB    = 52;
    localparam int DP_BIAS       = 1023;
    localparam int DP_DENORM_EXP = -1022;
    localparam int DP_HI_EXP_LSB = 20;
    localparam int DP_HI_MAN_MSB = 19;
    localparam logic [10:0] DP_EXP_MAX_NORM = 11'h7_fe;
    localparam logic [10:0] DP_EXP_ONES     = 11'h7_ff;

    // Single precision layout
    localparam int SP_EXP_W      = 8;
    localparam int SP_MAN_W      = 23;
    localparam int SP_SIGN_POS   = 31;
    localparam int SP_EXP_LSB    = 23;
    localparam int SP_BIAS       = 127;
    localparam logic [7:0] SP_EXP_ONES = 8'hff;

    // Exception bit positions
    localparam int EXC_INVALID  = 4;
    localparam int EXC_DIVZERO  = 3;
    localparam int EXC_OVERFLOW = 2;
    localparam int EXC_UNDERFLOW = 1;
    localparam int EXC_INEXACT  = 0;

    typedef enum logic [1:0] {
        round_nearest          = 2'h0,
        round_toward_zero      = 2'h1,
        round_toward_plus_inf  = 2'h2,
        round_toward_minus_inf = 2'h3
    } round_mode_t;

    typedef struct packed {
        logic is_zero;
        logic is_denorm;
        logic is_normal;
        logic is_inf;
        logic is_qnan;
        logic is_snan;
    } fp_class_t;

    typedef struct packed {
        logic        sign;
        logic [10:0] exp;
        logic [51:0] man;
    } dp_fields_t;

    typedef struct packed {
        fp_class_t   cls;
        dp_fields_t  f;
        logic        dbl;
    } fp_unpacked_t;

endpackage

// file: fp_format_classifier.sv
`timescale 1ns/1ps
// Behaviour
// (RULE_01) Four rounding choices; nearest ties go toward zero.
// (RULE_02) Result equals exact value rounded once by the selected choice.
// (RULE_03) Detect invalid, divide by zero, overflow, underflow, inexact.
// (RULE_04) Untrapped overflow/divide give signed infinity; invalid gives a NaN. Code gives largest value on overflow toward zero or against sign.
// (RULE_05) Quiet NaN operand gives NaN silently; signalling NaN raises invalid.
// (RULE_06) Each exception class can be trapped separately by software.
// (RULE_07) Double exponent is 11 bits with bias 1023.
// (RULE_08) Compare uses signed-integer logic on the same bit patterns.
// (RULE_09) Double exponents 1..2046 are normal; all-zero and all-one reserved.
// (RULE_10) Separate sign bit, 0 positive, 1 negative; mantissa is magnitude.
// (RULE_11) Normal double: hidden one, value 1.m times 2^(E-1023).
// (RULE_12) Zero exponent: zero if mantissa zero, else denormal 0.m*2^-1022.
// (RULE_13) Denormal operands or results are handed to software.
// (RULE_14) All-ones exponent: infinity if mantissa zero, else NaN.
// (RULE_15) NaN is quiet if mantissa MSB zero, signalling if one.
// (RULE_16) Single: sign bit 31, exponent 30..23, mantissa 22..0.
// (RULE_17) Double high word: sign 31, exponent 30..20, mantissa 19..0.
// (RULE_18) Double in memory: big-endian high word first, little low first.
// (RULE_19) Two-bit rounding field: 0 nearest, 1 zero, 2 plus, 3 minus.
// (RULE_20) Overflow yields infinity or largest value by rounding choice.
// (RULE_21) Cause, enable, flag are five bits: invalid,divzero,ovf,unf,inexact.
// (RULE_22) Exactly one class asserted per unpacked operand.
module fp_format_classifier (
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_valid,
    input  wire logic                       i_dbl,
    input  wire logic                       i_from_mem,
    input  wire logic                       i_big_endian,
    input  wire logic [63:0]                i_op_a,
    input  wire logic [63:0]                i_op_b,
    input  wire logic [1:0]                 i_round_mode,
    input  wire logic [4:0]                 i_trap_enable,
    input  wire logic                       i_res_sign,
    input  wire logic [12:0]                i_res_exp,
    input  wire logic [55:0]                i_res_man,
    input  wire logic                       i_res_sticky,
    input  wire logic                       i_div_by_zero,
    input  wire logic                       i_invalid_op,
    output logic                            o_valid,
    output fp_fmt_pkg::fp_unpacked_t        o_unp_a,
    output fp_fmt_pkg::fp_unpacked_t        o_unp_b,
    output logic                            o_a_lt_b,
    output logic                            o_a_eq_b,
    output logic                            o_unordered,
    output logic [63:0]                     o_result,
    output logic [4:0]                      o_cause,
    output logic                            o_trap,
    output logic                            o_unimpl
);
    import fp_fmt_pkg::*;

    // Operand reordering for memory doubles
    function automatic logic [63:0] fix_order(input logic [63:0] w, input logic mem,
                                              input logic big);
        // Memory image: bits 31:0 are the lower address word
        if (mem && big) begin
            fix_order = {w[31:0], w[63:32]}; // RULE_18
        end else begin
            fix_order = w; // RULE_18
        end
    endfunction

    function automatic fp_unpacked_t unpack(input logic [63:0] w, input logic dbl);
        fp_unpacked_t u;
        logic         ez;
        logic         eo;
        logic         mz;
        logic         mmsb;
        u = '0;
        u.dbl = dbl;
        if (dbl) begin
            u.f.sign = w[DP_SIGN_POS]; // RULE_10 RULE_17
            u.f.exp  = w[DP_SIGN_POS-1:DP_EXP_LSB]; // RULE_07 RULE_17
            u.f.man  = w[DP_MAN_W-1:0]; // RULE_17
            ez   = (u.f.exp == '0);
            eo   = (u.f.exp == DP_EXP_ONES); // RULE_14
            mz   = (u.f.man == '0);
            mmsb = u.f.man[DP_MAN_W-1];
        end else begin
            // Single widened: exponent and mantissa left in native field
            u.f.sign = w[SP_SIGN_POS]; // RULE_16
            u.f.exp  = {3'h0, w[SP_SIGN_POS-1:SP_EXP_LSB]}; // RULE_16
            u.f.man  = {29'h0, w[SP_MAN_W-1:0]}; // RULE_16
            ez   = (w[SP_SIGN_POS-1:SP_EXP_LSB] == '0);
            eo   = (w[SP_SIGN_POS-1:SP_EXP_LSB] == SP_EXP_ONES);
            mz   = (w[SP_MAN_W-1:0] == '0);
            mmsb = w[SP_MAN_W-1];
        end
        u.cls.is_zero   = ez && mz; // RULE_12
        u.cls.is_denorm = ez && !mz; // RULE_12
        u.cls.is_normal = !ez && !eo; // RULE_09 RULE_11
        u.cls.is_inf    = eo && mz; // RULE_14
        u.cls.is_qnan   = eo && !mz && !mmsb; // RULE_15
        u.cls.is_snan   = eo && !mz && mmsb; // RULE_15
        return u;
    endfunction

    logic [63:0]  wa;
    logic [63:0]  wb;
    fp_unpacked_t ua;
    fp_unpacked_t ub;
    logic         lt_c;
    logic         eq_c;
    logic         unord_c;

    always_comb begin
        wa = fix_order(i_op_a, i_from_mem && i_dbl, i_big_endian);
        wb = fix_order(i_op_b, i_from_mem && i_dbl, i_big_endian);
        ua = unpack(wa, i_dbl);
        ub = unpack(wb, i_dbl);
    end

    // Compare as sign-magnitude integers; zeros of both signs are equal
    always_comb begin
        logic [62:0] ma;
        logic [62:0] mb;
        ma = i_dbl ? wa[62:0] : {32'h0, wa[30:0]};
        mb = i_dbl ? wb[62:0] : {32'h0, wb[30:0]};
        unord_c = ua.cls.is_qnan || ua.cls.is_snan || ub.cls.is_qnan || ub.cls.is_snan;
        eq_c = !unord_c && ((ma == mb && ua.f.sign == ub.f.sign)
                            || (ua.cls.is_zero && ub.cls.is_zero)); // RULE_08
        if (unord_c || eq_c) begin
            lt_c = 1'b0;
        end else if (ua.f.sign != ub.f.sign) begin
            lt_c = ua.f.sign; // RULE_08
        end else begin
            lt_c = ua.f.sign ? (ma > mb) : (ma < mb); // RULE_08
        end
    end

    // Rounding and packing of the result
    // Result mantissa: [55] hidden one, then fraction, then guard and round bits.
    // Exact value is supplied with a sticky bit; rounding is applied once here.
    logic [63:0] res_c;
    logic [4:0]  cause_c;
    logic        unimpl_c;

    always_comb begin
        logic [52:0] frac;
        logic [1:0]  gr;
        logic        inexact;
        logic        up;
        logic        half;
        logic        above;
        logic [53:0] rnd;
        logic [12:0] e;
        logic        ovf;
        logic        tiny;
        logic        nan_in;
        logic        snan_in;
        logic [12:0] emax;
        logic [4:0]  shift;
        logic [52:0] mr;
        frac    = '0;
        gr      = '0;
        up      = 1'b0;
        rnd     = '0;
        mr      = '0;
        inexact = 1'b0;
        half    = 1'b0;
        above   = 1'b0;
        e       = '0;
        ovf     = 1'b0;
        tiny    = 1'b0;
        nan_in  = 1'b0;
        snan_in = 1'b0;
        res_c   = '0;
        cause_c = '0;
        emax    = i_dbl ? 13'h0_7fe : 13'h0_0fe;
        shift   = i_dbl ? 5'h00 : 5'h1d;
        // Single keeps its 24-bit mantissa in the top of the field
        frac = i_res_man[55:3];
        gr   = i_dbl ? i_res_man[2:1] : i_res_man[31:30];
        inexact = i_dbl ? (|i_res_man[2:0] || i_res_sticky)
                        : (|i_res_man[31:0] || i_res_sticky);
        half  = gr[1] && !gr[0] && (i_dbl ? !i_res_man[0] : ~|i_res_man[29:0])
                && !i_res_sticky;
        above = gr[1] && !half;
        unique case (round_mode_t'(i_round_mode)) // RULE_19
            round_nearest:          up = above; // RULE_01
            round_toward_zero:      up = 1'b0; // RULE_01
            round_toward_plus_inf:  up = inexact && !i_res_sign; // RULE_01
            round_toward_minus_inf: up = inexact && i_res_sign; // RULE_01
        endcase
        // Single mantissa LSB sits at bit 29 of the shared field
        rnd = {1'b0, frac} + (i_dbl ? 54'h1 : 54'h2000_0000); // RULE_02
        rnd = up ? rnd : {1'b0, frac};
        e   = i_res_exp;
        if (rnd[53]) begin
            rnd = rnd >> 1;
            e   = e + 13'h1;
        end
        mr   = rnd[52:0] >> shift;
        ovf  = !e[12] && (e > emax);
        tiny = e[12] || (e == '0) || (i_res_man[55] == 1'b0);
        nan_in  = ua.cls.is_qnan || ua.cls.is_snan || ub.cls.is_qnan || ub.cls.is_snan;
        snan_in = ua.cls.is_snan || ub.cls.is_snan;
        cause_c[EXC_INVALID]  = i_invalid_op || snan_in; // RULE_03 RULE_05
        cause_c[EXC_DIVZERO]  = i_div_by_zero && !nan_in; // RULE_03
        cause_c[EXC_OVERFLOW] = ovf && !nan_in && !i_div_by_zero; // RULE_03
        cause_c[EXC_UNDERFLOW] = tiny && inexact && !nan_in; // RULE_03
        cause_c[EXC_INEXACT]  = (inexact || ovf) && !nan_in && !i_div_by_zero; // RULE_03
        if (cause_c[EXC_INVALID] || nan_in) begin
            // Default quiet NaN: mantissa MSB clear, rest ones
            res_c = i_dbl ? {1'b0, DP_EXP_ONES, 1'b0, 51'h7_ffff_ffff_ffff}
                          : {32'h0, 1'b0, SP_EXP_ONES, 1'b0, 22'h3f_ffff}; // RULE_04 RULE_05
        end else if (i_div_by_zero || (ovf && (i_round_mode == round_nearest
                     || (i_round_mode == round_toward_plus_inf && !i_res_sign)
                     || (i_round_mode == round_toward_minus_inf && i_res_sign)))) begin
            res_c = i_dbl ? {i_res_sign, DP_EXP_ONES, 52'h0}
                          : {32'h0, i_res_sign, SP_EXP_ONES, 23'h0}; // RULE_04 RULE_20
        end else if (ovf) begin
            res_c = i_dbl ? {i_res_sign, DP_EXP_MAX_NORM, {52{1'b1}}}
                          : {32'h0, i_res_sign, 8'hfe, 23'h7f_ffff}; // RULE_20
        end else if (i_dbl) begin
            res_c = {i_res_sign, e[10:0], mr[51:0]}; // RULE_11
        end else begin
            res_c = {32'h0, i_res_sign, e[7:0], mr[22:0]};
        end
        // Denormal in or out goes to software; a NaN in does not punt here
        unimpl_c = ua.cls.is_denorm || ub.cls.is_denorm || (tiny && !nan_in
                   && !i_div_by_zero && !cause_c[EXC_INVALID]); // RULE_13
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_valid     <= 1'b0;
            o_unp_a     <= '0;
            o_unp_b     <= '0;
            o_a_lt_b    <= 1'b0;
            o_a_eq_b    <= 1'b0;
            o_unordered <= 1'b0;
            o_result    <= '0;
            o_cause     <= '0;
            o_trap      <= 1'b0;
            o_unimpl    <= 1'b0;
        end else begin
            o_valid     <= i_valid;
            o_unp_a     <= ua;
            o_unp_b     <= ub;
            o_a_lt_b    <= lt_c;
            o_a_eq_b    <= eq_c;
            o_unordered <= unord_c;
            o_result    <= res_c;
            o_cause     <= i_valid ? cause_c : 5'h0_0; // RULE_21
            o_trap      <= i_valid && (|(cause_c & i_trap_enable) || unimpl_c); // RULE_06
            o_unimpl    <= i_valid && unimpl_c; // RULE_13
        end
    end

    // Gated by o_valid: the reset value of the class vector is all zero
    a_one_class_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_22
        o_valid |-> $onehot(o_unp_a.cls)) else $error("operand a class not one-hot");
    a_one_class_b: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_22
        o_valid |-> $onehot(o_unp_b.cls)) else $error("operand b class not one-hot");
    a_snan_invalid: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_05
        i_valid && (ua.cls.is_snan || ub.cls.is_snan) |=> o_cause[EXC_INVALID])
        else $error("signalling NaN did not raise invalid");
    a_qnan_silent: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_05
        i_valid && ua.cls.is_qnan && !ub.cls.is_snan && !i_invalid_op
        |=> o_cause == 5'h0_0) else $error("quiet NaN raised exception");
    a_denorm_punt: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_13
        i_valid && (ua.cls.is_denorm || ub.cls.is_denorm) |=> o_unimpl && o_trap)
        else $error("denormal operand not handed to software");
    a_trap_enable: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_06
        o_valid && |(o_cause & $past(i_trap_enable)) |-> o_trap)
        else $error("enabled exception did not trap");
    a_divz_inf: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_04
        i_valid && i_dbl && i_div_by_zero && !i_invalid_op && !unord_c
        |=> o_result[62:52] == DP_EXP_ONES && o_result[51:0] == '0
            && o_result[63] == $past(i_res_sign)) else $error("divide by zero not infinity");
    a_dbl_normal: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_09
        o_unp_a.dbl && o_unp_a.cls.is_normal |-> o_unp_a.f.exp >= 11'h001
            && o_unp_a.f.exp <= DP_EXP_MAX_NORM) else $error("normal exponent out of range");
    a_cmp_order: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // RULE_08
        !(o_a_lt_b && o_a_eq_b) && !(o_unordered && (o_a_lt_b || o_a_eq_b)))
        else $error("compare outputs inconsistent");

endmodule // fp_format_classifier

// file: fp_mem_port_model.sv
`timescale 1ns/1ps
module fp_mem_port_model (
    input  wire logic        i_big_endian,
    input  wire logic [63:0] i_val_a,
    input  wire logic [63:0] i_val_b,
    output logic      [63:0] o_img_a,
    output logic      [63:0] o_img_b
);
    // Bits 31:0 hold the word at the lower address
    always_comb begin
        if (i_big_endian) begin
            o_img_a = {i_val_a[31:0], i_val_a[63:32]};
            o_img_b = {i_val_b[31:0], i_val_b[63:32]};
        end else begin
            o_img_a = i_val_a;
            o_img_b = i_val_b;
        end
    end
endmodule // fp_mem_port_model

// file: test_fp_format_classifier.sv
`timescale 1ns/1ps
module test_fp_format_classifier;
    import fp_fmt_pkg::*;
    logic i_sys_clk = 0, i_rstn = 0, i_valid = 0, i_dbl = 0, i_from_mem = 0, i_big_endian = 0;
    logic [1:0] i_round_mode = 0;
    logic [4:0] i_trap_enable = 0;
    logic i_res_sign = 0, i_res_sticky = 0, i_div_by_zero = 0, i_invalid_op = 0;
    logic [12:0] i_res_exp = 0;
    logic [55:0] i_res_man = 0;
    logic [63:0] va = 0, vb = 0, img_a, img_b, e_fa, e_fb, e_res, o_result;
    wire  [63:0] i_op_a = i_from_mem ? img_a : va;
    wire  [63:0] i_op_b = i_from_mem ? img_b : vb;
    logic o_valid, o_a_lt_b, o_a_eq_b, o_unordered, o_trap, o_unimpl;
    logic [4:0] o_cause, e_cause, e_en;
    fp_unpacked_t o_unp_a, o_unp_b;
    fp_class_t e_ca, e_cb;
    logic [2:0] e_cmp;
    logic e_valid, e_dbl, e_den, e_snan, e_qonly, e_clean, e_inv, e_tiny;
    logic [51:0] m52;
    logic [3:0] grxs;
    int bad_count = 0, checked = 0, ka, kb, rk;

    always #25 i_sys_clk = ~i_sys_clk;

    fp_mem_port_model pm (.i_big_endian(i_big_endian), .i_val_a(va), .i_val_b(vb),
                          .o_img_a(img_a), .o_img_b(img_b));
    fp_format_classifier dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_valid(i_valid),
        .i_dbl(i_dbl), .i_from_mem(i_from_mem), .i_big_endian(i_big_endian),
        .i_op_a(i_op_a), .i_op_b(i_op_b), .i_round_mode(i_round_mode),
        .i_trap_enable(i_trap_enable), .i_res_sign(i_res_sign), .i_res_exp(i_res_exp),
        .i_res_man(i_res_man), .i_res_sticky(i_res_sticky), .i_div_by_zero(i_div_by_zero),
        .i_invalid_op(i_invalid_op), .o_valid(o_valid), .o_unp_a(o_unp_a), .o_unp_b(o_unp_b),
        .o_a_lt_b(o_a_lt_b), .o_a_eq_b(o_a_eq_b), .o_unordered(o_unordered),
        .o_result(o_result), .o_cause(o_cause), .o_trap(o_trap), .o_unimpl(o_unimpl));

    function automatic fp_class_t cls(input logic [63:0] v, input logic d);
        logic [10:0] e;
        logic [51:0] m;
        fp_class_t   c;
        e = d ? v[62:52] : {3'h0, v[30:23]};
        m = d ? v[51:0] : {v[22:0], 29'h0};
        c = '0;
        if (e == 11'h0) begin
            c.is_zero   = (m == 52'h0);
            c.is_denorm = (m != 52'h0);
        end else if (e == (d ? DP_EXP_ONES : {3'h0, SP_EXP_ONES})) begin
            c.is_inf  = (m == 52'h0);
            c.is_qnan = (m != 52'h0) & !m[51];
            c.is_snan = (m != 52'h0) & m[51];
        end else begin
            c.is_normal = 1'b1;
        end
        return c;
    endfunction

    // Kinds: 0 zero, 1 denormal, 2 normal, 3 infinity, 4 quiet NaN, 5 signalling NaN
    function automatic logic [63:0] mk(input int k, input logic d);
        logic [51:0] m;
        logic [10:0] e;
        logic        s;
        m = 52'({$urandom, $urandom});
        m[29] = 1'b1;
        s = 1'($urandom);
        e = (k < 2) ? 11'h0 : (k == 2) ? 11'(1 + $urandom % (d ? 2046 : 254)) : 11'h7ff;
        if (k == 0 || k == 3) m = 52'h0;
        if (k == 4) m[51] = 1'b0;
        if (k == 5) m[51] = 1'b1;
        return d ? {s, e, m} : {32'h0, s, e[7:0], m[51:29]};
    endfunction

    function automatic logic [2:0] cmp(input logic [63:0] a, input logic [63:0] b,
                                       input logic d);
        fp_class_t   ca, cb;
        logic [62:0] ma, mb;
        logic        sa, sb;
        ca = cls(a, d);
        cb = cls(b, d);
        sa = d ? a[63] : a[31];
        sb = d ? b[63] : b[31];
        ma = d ? a[62:0] : {32'h0, a[30:0]};
        mb = d ? b[62:0] : {32'h0, b[30:0]};
        if (ca.is_qnan | ca.is_snan | cb.is_qnan | cb.is_snan) return 3'h1;
        if ((ca.is_zero & cb.is_zero) || (sa == sb && ma == mb)) return 3'h2;
        if (sa != sb) return {sa, 2'h0};
        return {(ma < mb) ^ sa, 2'h0};
    endfunction

    // Returns {cause, result}; grxs is guard, round, extra, sticky
    function automatic logic [68:0] res_exp(input int k, input logic [1:0] md, input logic s,
                                            input logic [51:0] m, input logic [3:0] grxs);
        logic inx, up, inf;
        inx = |grxs;
        inf = (md == 2'h0) | (md == 2'h2 & !s) | (md == 2'h3 & s);
        up  = (md == 2'h0) ? grxs[3] & |grxs[2:0] : (md == 2'h2) ? !s & inx
                                                                  : (md == 2'h3) & s & inx;
        case (k)
            2: return {5'h05, s, inf ? {DP_EXP_ONES, 52'h0} : {DP_EXP_MAX_NORM, {52{1'b1}}}};
            3: return {5'h08, s, DP_EXP_ONES, 52'h0};
            4: return {5'h10, 1'b0, DP_EXP_ONES, 1'b0, {51{1'b1}}};
            5: return {3'h0, inx, inx, s, 11'h0, m + 52'(up)};
            default: return {4'h0, inx, s, 11'h3ff, m + 52'(up)};
        endcase
    endfunction

    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check();
        chk(o_valid === e_valid, "valid flag");
        if (e_valid) begin
            chk(o_unp_a.cls === e_ca && o_unp_b.cls === e_cb, "class");
            if (e_dbl) chk(o_unp_a.f === e_fa && o_unp_b.f === e_fb, "fields");
            chk({o_a_lt_b, o_a_eq_b, o_unordered} === e_cmp, "compare");
            if (e_den) chk(o_unimpl === 1'b1 && o_trap === 1'b1, "denormal");
            if (e_snan) chk(o_cause[EXC_INVALID] === 1'b1, "signalling nan");
            if (e_qonly) chk(o_cause[EXC_INVALID] === 1'b0, "quiet nan");
            if (e_clean) begin
                chk(o_cause === e_cause && o_unimpl === e_tiny, "cause");
                chk(o_unimpl === e_tiny, "tiny result");
                chk(o_trap === (|(e_cause & e_en) || e_tiny), "trap");
                chk(e_inv ? o_result[62:0] === e_res[62:0] : o_result === e_res, "result");
            end
        end else begin
            chk(o_cause === 5'h00, "idle cause");
        end
    endtask

    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge i_sys_clk);
            if (i > 0) check();
            i_valid = (i < 44) || ($urandom % 8 != 0);
            i_dbl = (i >= 36 && i < 44) || 1'($urandom);
            i_from_mem = i_dbl & 1'($urandom);
            i_big_endian = 1'($urandom);
            i_round_mode = 2'($urandom);
            i_trap_enable = 5'($urandom);
            ka = $urandom % 6;
            kb = $urandom % 6;
            if (i < 36) begin
                ka = i % 6;
                kb = i / 6;
            end
            rk = $urandom % 6;
            m52 = 52'({$urandom, $urandom});
            m52[51] = 1'b0;
            grxs = (rk == 1 || rk == 2 || rk == 5) ? 4'($urandom) : 4'h0;
            // Exact halfway and just-above-halfway in every rounding choice
            if (i >= 36 && i < 44) begin
                ka = 2;
                kb = 2;
                rk = 1;
                i_round_mode = 2'(i % 4);
                grxs = (i < 40) ? 4'h8 : 4'h9;
            end
            va = mk(ka, i_dbl);
            vb = mk(kb, i_dbl);
            i_res_sign = 1'($urandom);
            // Kind 5 is a tiny result with a zero exponent
            i_res_exp = (rk == 2) ? 13'h0_800 : (rk == 5) ? 13'h0_000 : 13'h0_3ff;
            i_res_man = {1'b1, m52, grxs[3:1]};
            i_res_sticky = grxs[0];
            i_div_by_zero = (rk == 3);
            i_invalid_op = (rk == 4);
            e_ca = cls(va, i_dbl);
            e_cb = cls(vb, i_dbl);
            e_valid = i_valid;
            e_dbl = i_dbl;
            e_fa = va;
            e_fb = vb;
            e_cmp = cmp(va, vb, i_dbl);
            e_den = e_ca.is_denorm | e_cb.is_denorm;
            e_snan = e_ca.is_snan | e_cb.is_snan;
            e_qonly = (e_ca.is_qnan | e_cb.is_qnan) & !e_snan & !e_den & (rk < 2);
            e_clean = i_dbl & (e_ca.is_zero | e_ca.is_normal) & (e_cb.is_zero | e_cb.is_normal);
            {e_cause, e_res} = res_exp(rk, i_round_mode, i_res_sign, m52, grxs);
            e_inv = (rk == 4);
            e_tiny = (rk == 5);
            e_en = i_trap_enable;
        end
    endtask

    task automatic reset_check();
        @(negedge i_sys_clk);
        i_rstn = 1'b0;
        repeat (6) @(negedge i_sys_clk);
        chk(o_valid === 1'b0 && o_cause === 5'h00 && o_result === 64'h0 && o_trap === 1'b0,
            "reset outputs");
        i_rstn = 1'b1;
    endtask

    initial begin
        void'($urandom(59));
        reset_check();
        run(400);
        reset_check();
        run(300);
        close_out();
    end
endmodule // test_fp_format_classifier
